/* shared/lpm_clock_pkg.sv */
// Constants and types shared by the low-power mode and clock switch block
package lpm_clock_pkg;

	// Control word layout of system_control_two
	localparam int CTRL_W          = 8;
	localparam int HI_OSC_BIT      = 7;
	localparam int LO_OSC_BIT      = 6;
	localparam int CLK_SEL_BIT     = 5;
	localparam int TG_HALT_BIT     = 2;

	// Reset values of the control bits
	localparam logic RST_HI_OSC    = 1'b1;
	localparam logic RST_LO_OSC    = 1'b0;
	localparam logic RST_CLK_SEL   = 1'b0;

	// Program counter kept during a halt
	localparam int         PC_W            = 16;
	localparam logic [15:0] HALT_PC_OFFSET = 16'h0002;

	// Time base source taps
	localparam int TB_TAP_COUNT    = 8;
	localparam int TB_SEL_W        = 3;

	// Timing
	localparam int CLK_PERIOD_NS   = 10;
	localparam int SYSRST_TIME_NS  = 500;
	localparam int SYSRST_CYCLES   = (SYSRST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYSRST_CNT_W    = 7;

	// Operating modes
	typedef enum logic [2:0] {
		RESET_DEFAULT_RUN,
		DUAL_CLOCK_FAST_RUN,
		SLOW_RUN_OSC_ON,
		SLOW_RUN_OSC_OFF,
		TG_HALT_IDLE,
		TG_HALT_SLEEP
	} run_mode_e;

	// Main clock changeover sequence
	typedef enum logic [2:0] {
		SW_HIGH,
		SW_HI_DROP,
		SW_LO_RAISE,
		SW_LOW,
		SW_LO_DROP,
		SW_HI_RAISE
	} clk_switch_e;

endpackage : lpm_clock_pkg

/* rtl/fall_edge_detect.sv */
// Registered falling-edge detector for a synchronous level
`timescale 1ns/1ns
module fall_edge_detect (
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic rst,
	// Level in, one-cycle pulse out
	input  wire logic level,
	output logic      fall
);
	import lpm_clock_pkg::*;

	typedef struct packed {
		logic prev;
		logic fall;
	} edge_s;

	edge_s st;
	edge_s next_st;

	always_comb begin
		next_st      = st;
		next_st.prev = level;
		next_st.fall = st.prev & ~level;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign fall = st.fall;

endmodule : fall_edge_detect

/* rtl/low_power_mode_clock_switch.sv */
// Time-base halt modes and glitch-free main clock changeover
`timescale 1ns/1ns
module low_power_mode_clock_switch (
	// Clock and reset
	input  wire logic                                 ref_clk,
	input  wire logic                                 rst,
	// Control word write and read-back
	input  wire logic                                 ctrlWrite,
	input  wire logic [lpm_clock_pkg::CTRL_W-1:0]     ctrlWriteData,
	output logic      [lpm_clock_pkg::CTRL_W-1:0]     ctrlReadData,
	// Processor context
	input  wire logic [lpm_clock_pkg::PC_W-1:0]       entryAddr,
	input  wire logic                                 masterIntEnable,
	input  wire logic                                 timeBaseIntEnable,
	input  wire logic                                 watchdogIntPending,
	// Time base controls and source taps
	input  wire logic                                 timeBaseEnable,
	input  wire logic [lpm_clock_pkg::TB_SEL_W-1:0]   timeBaseSourceSelect,
	input  wire logic [lpm_clock_pkg::TB_TAP_COUNT-1:0] tbSourceTaps,
	// Oscillator levels, sampled
	input  wire logic                                 hiClkLevel,
	input  wire logic                                 loClkLevel,
	// Halt state and results
	output logic                                      tgHaltStatus,
	output lpm_clock_pkg::run_mode_e                  runMode,
	output logic                                      periphClockEnable,
	output logic                                      tbtClockEnable,
	output logic                                      cpuHold,
	output logic      [lpm_clock_pkg::PC_W-1:0]       haltPc,
	output logic                                      tbIntLatchSet,
	output logic                                      tbIntService,
	output logic                                      resumeNext,
	output logic                                      wdtIntService,
	// Oscillators and clock gates
	output logic                                      hiOscEnable,
	output logic                                      loOscEnable,
	output logic                                      clkSelLow,
	output logic                                      hiClkGate,
	output logic                                      loClkGate,
	output logic                                      sysClockReset
);
	import lpm_clock_pkg::*;

	typedef struct packed {
		run_mode_e                 mode;
		run_mode_e                 savedMode;
		logic                      timing_gen_halt_bit;
		logic                      hiOsc;
		logic                      loOsc;
		logic                      clkSel;
		clk_switch_e               sw;
		logic                      hiGate;
		logic                      loGate;
		logic                      periphClkEn;
		logic                      tbtClkEn;
		logic                      cpuHold;
		logic [PC_W-1:0]           haltPc;
		logic                      tbLatchSet;
		logic                      tbService;
		logic                      resumeNext;
		logic                      wdtService;
		logic [SYSRST_CNT_W-1:0]   sysRstCnt;
		logic                      sysRst;
		logic [CTRL_W-1:0]         ctrlRead;
	} state_s;

	localparam state_s RESET_STATE = '{
		mode:        RESET_DEFAULT_RUN,
		savedMode:   RESET_DEFAULT_RUN,
		timing_gen_halt_bit:      1'b0,
		hiOsc:       RST_HI_OSC,
		loOsc:       RST_LO_OSC,
		clkSel:      RST_CLK_SEL,
		sw:          SW_HIGH,
		hiGate:      1'b1,
		loGate:      1'b0,
		periphClkEn: 1'b1,
		tbtClkEn:    1'b1,
		cpuHold:     1'b0,
		haltPc:      '0,
		tbLatchSet:  1'b0,
		tbService:   1'b0,
		resumeNext:  1'b0,
		wdtService:  1'b0,
		sysRstCnt:   '0,
		sysRst:      1'b0,
		ctrlRead:    CTRL_W'({RST_HI_OSC, RST_LO_OSC, RST_CLK_SEL}) << CLK_SEL_BIT
	};

	localparam logic [SYSRST_CNT_W-1:0] SYSRST_LOAD = SYSRST_CNT_W'(SYSRST_CYCLES);

	state_s st;
	state_s next_st;

	logic tbFall;
	logic hiFall;
	logic loFall;
	logic haltRequest;
	logic allIntEnabled;
	logic badClockCombo;

	// Falling edges of the selected time base source and of both oscillators
	fall_edge_detect u_tb_fall (
		.ref_clk (ref_clk),
		.rst     (rst),
		.level   (tbSourceTaps[timeBaseSourceSelect]),
		.fall    (tbFall)
	);

	fall_edge_detect u_hi_fall (
		.ref_clk (ref_clk),
		.rst     (rst),
		.level   (hiClkLevel),
		.fall    (hiFall)
	);

	fall_edge_detect u_lo_fall (
		.ref_clk (ref_clk),
		.rst     (rst),
		.level   (loClkLevel),
		.fall    (loFall)
	);

	assign haltRequest   = ctrlWrite & ctrlWriteData[TG_HALT_BIT] & ~st.timing_gen_halt_bit;
	assign allIntEnabled = masterIntEnable & timeBaseIntEnable & timeBaseEnable;
	// Any of these leaves the main clock without a running oscillator
	assign badClockCombo = (~st.hiOsc & ~st.loOsc) | (~st.hiOsc & ~st.clkSel) |
		(~st.loOsc & st.clkSel);

	always_comb begin
		next_st            = st;
		next_st.tbLatchSet = 1'b0;
		next_st.tbService  = 1'b0;
		next_st.resumeNext = 1'b0;
		next_st.wdtService = 1'b0;
		next_st.tbtClkEn   = 1'b1;

		if (!st.timing_gen_halt_bit) begin
			if (ctrlWrite) begin
				next_st.hiOsc  = ctrlWriteData[HI_OSC_BIT];
				next_st.loOsc  = ctrlWriteData[LO_OSC_BIT];
				next_st.clkSel = ctrlWriteData[CLK_SEL_BIT];
			end
			if (next_st.clkSel) begin
				next_st.mode = next_st.hiOsc ? SLOW_RUN_OSC_ON : SLOW_RUN_OSC_OFF;
			end else begin
				next_st.mode = next_st.loOsc ? DUAL_CLOCK_FAST_RUN : RESET_DEFAULT_RUN;
			end
			if (haltRequest) begin
				if (watchdogIntPending) begin
					// Interrupt is serviced instead of halting
					next_st.wdtService = 1'b1;
				end else begin
					// Entry does not look at the time base enable
					next_st.timing_gen_halt_bit      = 1'b1;
					next_st.savedMode   = next_st.mode;
					next_st.mode        = next_st.clkSel ? TG_HALT_SLEEP : TG_HALT_IDLE;
					next_st.periphClkEn = 1'b0;
					next_st.cpuHold     = 1'b1;
					next_st.haltPc      = entryAddr + HALT_PC_OFFSET;
					next_st.tbLatchSet  = timeBaseEnable;
				end
			end
		end else if (tbFall) begin
			// First edge seen releases; the halt may be cut short
			next_st.timing_gen_halt_bit      = 1'b0;
			next_st.mode        = st.savedMode;
			next_st.periphClkEn = 1'b1;
			next_st.cpuHold     = 1'b0;
			if (allIntEnabled) begin
				next_st.tbService  = 1'b1;
			end else begin
				next_st.resumeNext = 1'b1;
			end
		end

		// Break-before-make changeover on falling edges of each clock
		case (st.sw)
			SW_HIGH: begin
				if (st.clkSel) begin
					next_st.sw = SW_HI_DROP;
				end
			end
			SW_HI_DROP: begin
				if (hiFall) begin
					next_st.hiGate = 1'b0;
					next_st.sw     = SW_LO_RAISE;
				end
			end
			SW_LO_RAISE: begin
				if (loFall) begin
					next_st.loGate = 1'b1;
					next_st.sw     = SW_LOW;
				end
			end
			SW_LOW: begin
				if (!st.clkSel) begin
					next_st.sw = SW_LO_DROP;
				end
			end
			SW_LO_DROP: begin
				// Keep running on low clock until its edge arrives
				if (loFall) begin
					next_st.loGate = 1'b0;
					next_st.sw     = SW_HI_RAISE;
				end
			end
			SW_HI_RAISE: begin
				if (hiFall) begin
					next_st.hiGate = 1'b1;
					next_st.sw     = SW_HIGH;
				end
			end
			default: begin
				next_st.sw     = SW_HIGH;
				next_st.hiGate = 1'b1;
				next_st.loGate = 1'b0;
			end
		endcase

		// Reset request stretched while the combination persists
		if (st.sysRstCnt > SYSRST_CNT_W'(1)) begin
			next_st.sysRstCnt = st.sysRstCnt - SYSRST_CNT_W'(1);
		end else if (badClockCombo) begin
			next_st.sysRstCnt = SYSRST_LOAD;
		end else begin
			next_st.sysRstCnt = '0;
		end
		next_st.sysRst = (next_st.sysRstCnt != '0);

		next_st.ctrlRead              = '0;
		next_st.ctrlRead[HI_OSC_BIT]  = next_st.hiOsc;
		next_st.ctrlRead[LO_OSC_BIT]  = next_st.loOsc;
		next_st.ctrlRead[CLK_SEL_BIT] = next_st.clkSel;
		next_st.ctrlRead[TG_HALT_BIT] = next_st.timing_gen_halt_bit;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= RESET_STATE;
		end else begin
			st <= next_st;
		end
	end

	assign ctrlReadData      = st.ctrlRead;
	assign tgHaltStatus      = st.timing_gen_halt_bit;
	assign runMode           = st.mode;
	assign periphClockEnable = st.periphClkEn;
	assign tbtClockEnable    = st.tbtClkEn;
	assign cpuHold           = st.cpuHold;
	assign haltPc            = st.haltPc;
	assign tbIntLatchSet     = st.tbLatchSet;
	assign tbIntService      = st.tbService;
	assign resumeNext        = st.resumeNext;
	assign wdtIntService     = st.wdtService;
	assign hiOscEnable       = st.hiOsc;
	assign loOscEnable       = st.loOsc;
	assign clkSelLow         = st.clkSel;
	assign hiClkGate         = st.hiGate;
	assign loClkGate         = st.loGate;
	assign sysClockReset     = st.sysRst;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	property p_halt_gates_periph;
		st.timing_gen_halt_bit |-> !periphClockEnable && tbtClockEnable;
	endproperty
	a_halt_gates_periph: assert property (p_halt_gates_periph)
		else $error("peripheral clock running during halt");

	property p_halt_holds_cpu;
		st.timing_gen_halt_bit && $past(st.timing_gen_halt_bit) |-> cpuHold && $stable(haltPc);
	endproperty
	a_halt_holds_cpu: assert property (p_halt_holds_cpu)
		else $error("processor not held during halt");

	property p_halt_pc;
		haltRequest && !watchdogIntPending |=> haltPc == $past(entryAddr) + 16'h0002;
	endproperty
	a_halt_pc: assert property (p_halt_pc)
		else $error("halt program counter not entry plus two");

	property p_halt_entry;
		haltRequest && !watchdogIntPending && !timeBaseEnable |=> tgHaltStatus && cpuHold;
	endproperty
	a_halt_entry: assert property (p_halt_entry)
		else $error("halt not entered without time base enable");

	property p_release_restores;
		st.timing_gen_halt_bit && tbFall |=> !tgHaltStatus && runMode == $past(st.savedMode) &&
			ctrlReadData[2] == 1'b0;
	endproperty
	a_release_restores: assert property (p_release_restores)
		else $error("release did not clear halt or restore mode");

	property p_tb_latch;
		haltRequest && !watchdogIntPending && timeBaseEnable |=> tbIntLatchSet ##1 !tbIntLatchSet;
	endproperty
	a_tb_latch: assert property (p_tb_latch)
		else $error("time base latch not set once at entry");

	property p_reset_default;
		$past(rst) |-> runMode == RESET_DEFAULT_RUN && !tgHaltStatus && hiClkGate && !loClkGate;
	endproperty
	a_reset_default: assert property (p_reset_default)
		else $error("not in default run mode after reset");

	property p_normal_release;
		st.timing_gen_halt_bit && tbFall && !allIntEnabled |=> resumeNext && !tbIntService;
	endproperty
	a_normal_release: assert property (p_normal_release)
		else $error("normal release did not resume");

	property p_int_release;
		st.timing_gen_halt_bit && tbFall && allIntEnabled |=> tbIntService && !resumeNext;
	endproperty
	a_int_release: assert property (p_int_release)
		else $error("interrupt release did not service time base");

	property p_wdt_blocks;
		haltRequest && watchdogIntPending |=> wdtIntService && !tgHaltStatus && periphClockEnable;
	endproperty
	a_wdt_blocks: assert property (p_wdt_blocks)
		else $error("halt entered despite watchdog interrupt");

	property p_osc_bits;
		ctrlWrite && !st.timing_gen_halt_bit |=> hiOscEnable == $past(ctrlWriteData[7]) &&
			clkSelLow == $past(ctrlWriteData[5]);
	endproperty
	a_osc_bits: assert property (p_osc_bits)
		else $error("oscillator or select bit not taken");

	property p_stay_low;
		st.sw == SW_LO_DROP && !loFall |=> loClkGate && !hiClkGate;
	endproperty
	a_stay_low: assert property (p_stay_low)
		else $error("left low clock before alignment");

	property p_no_overlap;
		!(hiClkGate && loClkGate);
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("both clock gates open");

	property p_sys_reset;
		badClockCombo |=> sysClockReset;
	endproperty
	a_sys_reset: assert property (p_sys_reset)
		else $error("no reset for stopped system clock");

	c_halt_entry:   cover property (haltRequest && !watchdogIntPending ##1 tgHaltStatus);
	c_int_release:  cover property (st.timing_gen_halt_bit && tbFall && allIntEnabled);
	c_to_low_clock: cover property ($rose(loClkGate));
	c_to_hi_clock:  cover property (st.sw == SW_HI_RAISE ##1 st.sw == SW_HIGH);

endmodule : low_power_mode_clock_switch

/* tb/tb_top.sv */
// Self-checking testbench for the low-power mode and clock switch block
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin checkCount++; if ((gt) !== (ex)) begin failures++; \
	$display("[ERR] %s expected %h seen %h", nm, ex, gt); end end
module tb_top;
	import lpm_clock_pkg::*;

	logic              ref_clk;
	logic              rst;
	logic              ctrlWrite;
	logic [7:0]        ctrlWriteData;
	logic [7:0]        ctrlReadData;
	logic [15:0]       entryAddr;
	logic              masterIntEnable;
	logic              timeBaseIntEnable;
	logic              watchdogIntPending;
	logic              timeBaseEnable;
	logic [2:0]        timeBaseSourceSelect;
	logic [7:0]        tbSourceTaps;
	logic              hiClkLevel;
	logic              loClkLevel;
	logic              tgHaltStatus;
	run_mode_e         runMode;
	logic              periphClockEnable;
	logic              tbtClockEnable;
	logic              cpuHold;
	logic [15:0]       haltPc;
	logic              tbIntLatchSet;
	logic              tbIntService;
	logic              resumeNext;
	logic              wdtIntService;
	logic              hiOscEnable;
	logic              loOscEnable;
	logic              clkSelLow;
	logic              hiClkGate;
	logic              loClkGate;
	logic              sysClockReset;
	int                failures;
	int                checkCount;
	int                cycles;
	logic [2:0]        oscCnt;

	low_power_mode_clock_switch uut (
		.ref_clk(ref_clk), .rst(rst),
		.ctrlWrite(ctrlWrite), .ctrlWriteData(ctrlWriteData), .ctrlReadData(ctrlReadData),
		.entryAddr(entryAddr), .masterIntEnable(masterIntEnable),
		.timeBaseIntEnable(timeBaseIntEnable), .watchdogIntPending(watchdogIntPending),
		.timeBaseEnable(timeBaseEnable), .timeBaseSourceSelect(timeBaseSourceSelect),
		.tbSourceTaps(tbSourceTaps), .hiClkLevel(hiClkLevel), .loClkLevel(loClkLevel),
		.tgHaltStatus(tgHaltStatus), .runMode(runMode), .periphClockEnable(periphClockEnable),
		.tbtClockEnable(tbtClockEnable), .cpuHold(cpuHold), .haltPc(haltPc),
		.tbIntLatchSet(tbIntLatchSet), .tbIntService(tbIntService), .resumeNext(resumeNext),
		.wdtIntService(wdtIntService), .hiOscEnable(hiOscEnable), .loOscEnable(loOscEnable),
		.clkSelLow(clkSelLow), .hiClkGate(hiClkGate), .loClkGate(loClkGate),
		.sysClockReset(sysClockReset)
	);

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// Oscillator levels: high clock toggles every cycle, low clock every four
	always @(posedge ref_clk) begin
		#1;
		oscCnt = oscCnt + 3'h1;
		hiClkLevel = oscCnt[0];
		loClkLevel = oscCnt[2];
	end

	always @(negedge ref_clk) begin
		if (rst === 1'b0) `CHK("both gates open", 1'b0, hiClkGate & loClkGate)
	end

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 1000) begin
			failures++;
			$display("[ERR] cycle limit expected finish seen hang");
			complete_run();
		end
	end

	task complete_run;
		$display("checks %0d failures %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : complete_run

	task do_reset;
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1;
		rst = 1'b0;
	endtask : do_reset

	// One strobe cycle; returns in the cycle where the answer shows
	task wr(input logic [7:0] d, input logic [15:0] a);
		@(posedge ref_clk);
		#1;
		ctrlWrite = 1'b1;
		ctrlWriteData = d;
		entryAddr = a;
		@(posedge ref_clk);
		#1;
		ctrlWrite = 1'b0;
	endtask : wr

	task wait_cycles(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : wait_cycles

	// Falling edge on the selected tap, then wait for the halt to end
	task fall_tap;
		int i;
		@(posedge ref_clk);
		#1;
		tbSourceTaps = 8'h08;
		@(posedge ref_clk);
		#1;
		tbSourceTaps = 8'h00;
		for (i = 0; i < 10 && tgHaltStatus !== 1'b0; i++) wait_cycles(1);
	endtask : fall_tap

	task wait_gate(input logic hi);
		int i;
		for (i = 0; i < 60 && (hi ? hiClkGate : loClkGate) !== 1'b1; i++) wait_cycles(1);
	endtask : wait_gate

	logic [7:0] modeData [4] = '{8'h80, 8'hc0, 8'he0, 8'h60};
	run_mode_e  modeExp  [4] = '{RESET_DEFAULT_RUN, DUAL_CLOCK_FAST_RUN, SLOW_RUN_OSC_ON,
		SLOW_RUN_OSC_OFF};

	initial begin
		rst = 1'b1;
		ctrlWrite = 1'b0;
		ctrlWriteData = 8'h00;
		entryAddr = 16'h0000;
		masterIntEnable = 1'b1;
		timeBaseIntEnable = 1'b1;
		watchdogIntPending = 1'b0;
		timeBaseEnable = 1'b1;
		timeBaseSourceSelect = 3'h3;
		tbSourceTaps = 8'h00;
		hiClkLevel = 1'b0;
		loClkLevel = 1'b0;
		oscCnt = 3'h0;
		failures = 0;
		checkCount = 0;
		cycles = 0;
		do_reset();
		`CHK("reset mode", RESET_DEFAULT_RUN, runMode)
		`CHK("reset readback", 8'h80, ctrlReadData)
		`CHK("reset gates", 2'b10, {hiClkGate, loClkGate})
		`CHK("time base clock", 1'b1, tbtClockEnable)
		for (int m = 0; m < 4; m++) begin
			wr(modeData[m], 16'h0000);
			`CHK("mode", modeExp[m], runMode)
			`CHK("readback", modeData[m], ctrlReadData)
			`CHK("stored bits", modeData[m][7:5], {hiOscEnable, loOscEnable, clkSelLow})
		end
		// Changeover in both directions; high oscillator warms up before select clears
		wr(8'he0, 16'h0000);
		wait_cycles(4);
		wr(8'hc0, 16'h0000);
		wait_gate(1'b1);
		`CHK("low gate at high", 1'b0, loClkGate)
		wr(8'he0, 16'h0000);
		`CHK("low gate early", 1'b0, loClkGate)
		wait_gate(1'b0);
		`CHK("high gate at low", 1'b0, hiClkGate)
		wr(8'hc0, 16'h0000);
		`CHK("still on low clock", 1'b1, loClkGate)
		wait_gate(1'b1);
		`CHK("low gate after return", 1'b0, loClkGate)
		// Idle halt from dual fast run, interrupt release
		wr(8'hc4, 16'h1234);
		`CHK("halt mode", TG_HALT_IDLE, runMode)
		`CHK("periph clock", 1'b0, periphClockEnable)
		`CHK("cpu frozen", 1'b1, cpuHold)
		`CHK("halt pc", 16'h1236, haltPc)
		`CHK("latch set", 1'b1, tbIntLatchSet)
		wr(8'h00, 16'h0000);
		`CHK("write in halt", 8'hc4, ctrlReadData)
		wait_cycles(1);
		tbSourceTaps = 8'h01;
		wait_cycles(1);
		tbSourceTaps = 8'h00;
		wait_cycles(4);
		`CHK("other tap ignored", 1'b1, tgHaltStatus)
		fall_tap();
		`CHK("released", 1'b0, tgHaltStatus)
		`CHK("service pulse", 2'b10, {tbIntService, resumeNext})
		`CHK("mode restored", DUAL_CLOCK_FAST_RUN, runMode)
		`CHK("halt bit cleared", 8'hc0, ctrlReadData)
		// Sleep halt with time base disabled, plain resume
		timeBaseEnable = 1'b0;
		wr(8'he4, 16'hfffe);
		`CHK("sleep mode", TG_HALT_SLEEP, runMode)
		`CHK("no latch", 1'b0, tbIntLatchSet)
		`CHK("pc wraps", 16'h0000, haltPc)
		fall_tap();
		`CHK("resume pulse", 2'b01, {tbIntService, resumeNext})
		`CHK("slow restored", SLOW_RUN_OSC_ON, runMode)
		`CHK("periph back", 1'b1, periphClockEnable)
		// Watchdog interrupt refuses entry
		timeBaseEnable = 1'b1;
		watchdogIntPending = 1'b1;
		wr(8'hc4, 16'h0100);
		`CHK("watchdog serviced", 2'b10, {wdtIntService, tgHaltStatus})
		watchdogIntPending = 1'b0;
		// Reset pin ends a halt
		wr(8'hc4, 16'h0200);
		`CHK("halted", 1'b1, tgHaltStatus)
		do_reset();
		`CHK("reset ends halt", 2'b00, {tgHaltStatus, cpuHold})
		`CHK("default run", RESET_DEFAULT_RUN, runMode)
		// Both oscillators off
		wr(8'h00, 16'h0000);
		wait_cycles(1);
		`CHK("clock reset", 1'b1, sysClockReset)
		wait_cycles(40);
		`CHK("clock reset held", 1'b1, sysClockReset)
		do_reset();
		`CHK("clock reset cleared", 1'b0, sysClockReset)
		complete_run();
	end
endmodule : tb_top
